// file: rtl/slb_params.svh
// Constants for the serial link self-test ends: register offsets, field positions,
// reset values and timing counts.
// Assumes a single 100 MHz clock aclk shared by both ends.
`ifndef SLB_PARAMS_SVH
`define SLB_PARAMS_SVH

`define SLB_REG_CTRL        8'h04
`define SLB_REG_STATUS      8'h0c
`define SLB_REG_CRCCNT      8'h10
`define SLB_REG_IRQ_STAT    8'h14
`define SLB_REG_IRQ_CLR     8'h18
`define SLB_REG_IRQ_EN      8'h1c
`define SLB_CTRL_CRCCLR_BIT 0
`define SLB_CTRL_ARM_BIT    5
`define SLB_STAT_LINK_BIT   0
`define SLB_STAT_TEST_BIT   1
`define SLB_STAT_REQ_BIT    2
`define SLB_STAT_CSEL_BIT   3
`define SLB_IRQ_ENTER       0
`define SLB_IRQ_LEAVE       1
`define SLB_IRQ_CRC         2
`define SLB_IRQ_LINK        3
`define SLB_RESP_OKAY       2'h0
`define SLB_RESP_SLVERR     2'h2
`define SLB_LFSR_SEED       35'h5a5a5a5a5
`define SLB_HEAVY_LIMIT     17
`define SLB_FRAME_CYC       64
`define SLB_BC_PERIOD       256
`define SLB_BC_TIMEOUT      1024
`define SLB_BC_LOCK_GOOD    4
`define SLB_FWD_LOCK_FRAMES 4

`endif

// file: rtl/slb_pkg.sv
// Types and shared coding functions of the serial link self-test ends.
// Assumes slb_params.svh is on the include path.
`include "slb_params.svh"
`default_nettype none

package slb_pkg;

    typedef logic [34:0] slb_word_t;

    typedef enum logic [1:0] {
        SLB_SER_NORMAL  = 2'b00,
        SLB_SER_ARMED   = 2'b01,
        SLB_SER_TEST    = 2'b10,
        SLB_SER_LEAVING = 2'b11
    } slb_ser_state_t;

    typedef enum logic [1:0] {
        SLB_DES_IDLE  = 2'b00,
        SLB_DES_WAIT  = 2'b01,
        SLB_DES_CHECK = 2'b10
    } slb_des_state_t;

    // Steps the scrambler sequence by one word.
    function automatic slb_word_t slb_lfsr_next(input slb_word_t x);
        return {x[33:0], x[34] ^ x[32]};
    endfunction : slb_lfsr_next

    // Computes the back-channel frame check byte.
    function automatic logic [7:0] slb_crc8(input logic [7:0] d);
        logic [7:0] c;
        c = d;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
        end
        return c;
    endfunction : slb_crc8

    // Tells whether a word holds more ones than zeroes.
    function automatic logic slb_heavy(input slb_word_t w);
        int n;
        n = 0;
        for (int i = 0; i < 35; i++) begin
            n = n + int'(w[i]);
        end
        return n > `SLB_HEAVY_LIMIT;
    endfunction : slb_heavy

endpackage : slb_pkg

`default_nettype wire

// file: rtl/slb_link_if.sv
// Link between serializer and deserializer: forward words and back-channel frames.
// Assumes both ends run on the same clock.
`default_nettype none

interface slb_link_if;
    import slb_pkg::*;

    logic       fwd_valid;
    logic       fwd_frame;
    slb_word_t  fwd_word;
    logic       fwd_dcb;
    logic       bc_valid;
    logic [7:0] bc_data;
    logic [7:0] bc_crc;

    modport ser (
        output fwd_valid, fwd_frame, fwd_word, fwd_dcb,
        input  bc_valid, bc_data, bc_crc
    );

    modport des (
        input  fwd_valid, fwd_frame, fwd_word, fwd_dcb,
        output bc_valid, bc_data, bc_crc
    );

endinterface : slb_link_if

`default_nettype wire

// file: rtl/slb_des.sv
// Deserializer end: test enable, back-channel sender, pattern checker, pass pin.
// Assumes the serializer reseeds its scrambler on every frame start.
`include "slb_params.svh"
`default_nettype none

module slb_des #(
    parameter int BC_PERIOD   = `SLB_BC_PERIOD,
    parameter int LOCK_FRAMES = `SLB_FWD_LOCK_FRAMES
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aclken,
    input  wire logic             aresetn,
    // Test control
    input  wire logic             selftest_enable_pin,
    input  wire logic             selftest_enable_cfg,
    input  wire logic             selftest_clock_select,
    // Results
    output var  logic             pass_q,
    output var  logic             lock_q,
    output var  logic [7:0]       err_count_q,
    output var  slb_pkg::slb_word_t rx_data_q,
    output var  logic             rx_frame_q,
    // Link
    slb_link_if.des               link
);
    import slb_pkg::*;

    slb_des_state_t state_q;
    slb_word_t      lfsr_q;
    logic [7:0]     bc_cnt_q;
    logic [3:0]     lock_cnt_q;
    logic           frame_err_q;
    logic           any_err_q;
    logic           bc_valid_q;
    logic [7:0]     bc_data_q;
    logic           enable;
    slb_word_t      scr;
    slb_word_t      dec;
    logic           word_err;

    assign enable   = selftest_enable_pin | selftest_enable_cfg;
    assign scr      = link.fwd_frame ? `SLB_LFSR_SEED : lfsr_q;
    assign dec      = (link.fwd_dcb ? ~link.fwd_word : link.fwd_word) ^ scr;
    assign word_err = link.fwd_valid && (dec != '0);

    assign link.bc_valid = bc_valid_q;
    assign link.bc_data  = bc_data_q;
    assign link.bc_crc   = slb_crc8(bc_data_q);

    // ****************************************
    // Back-channel frames
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bc_cnt_q   <= 8'h00;
            bc_valid_q <= 1'b0;
            bc_data_q  <= 8'h00;
        end else if (aclken) begin
            bc_cnt_q   <= (bc_cnt_q == 8'(BC_PERIOD - 1)) ? 8'h00 : bc_cnt_q + 8'h01;
            bc_valid_q <= (bc_cnt_q == 8'h00);
            if (bc_cnt_q == 8'h00) begin
                bc_data_q <= {6'h00, selftest_clock_select, enable};
            end
        end
    end

    // ****************************************
    // Descrambling and lock
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lfsr_q     <= `SLB_LFSR_SEED;
            lock_cnt_q <= 4'h0;
            lock_q     <= 1'b0;
            rx_data_q  <= '0;
            rx_frame_q <= 1'b0;
        end else if (aclken) begin
            rx_frame_q <= link.fwd_valid && link.fwd_frame;
            if (link.fwd_valid) begin
                lfsr_q    <= slb_lfsr_next(scr);
                rx_data_q <= dec;
                if (link.fwd_frame && !lock_q) begin
                    lock_cnt_q <= lock_cnt_q + 4'h1;
                    lock_q     <= (lock_cnt_q == 4'(LOCK_FRAMES - 1));
                end
            end else begin
                lock_cnt_q <= 4'h0;
                lock_q     <= 1'b0;
            end
        end
    end

    // ****************************************
    // Test sequence and pass pin
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q     <= SLB_DES_IDLE;
            pass_q      <= 1'b1;
            frame_err_q <= 1'b0;
            any_err_q   <= 1'b0;
            err_count_q <= 8'h00;
        end else if (aclken) begin
            case (state_q)
                SLB_DES_IDLE: begin
                    if (enable) begin
                        state_q     <= SLB_DES_WAIT;
                        any_err_q   <= 1'b0;
                        // A partial frame counts as dirty, so one whole clean frame is needed.
                        frame_err_q <= 1'b1;
                        err_count_q <= 8'h00;
                    end
                end
                SLB_DES_WAIT: begin
                    if (!enable) begin
                        state_q <= SLB_DES_IDLE;
                    end else if (link.fwd_valid && link.fwd_frame) begin
                        frame_err_q <= word_err;
                        if (lock_q && !frame_err_q) begin
                            state_q <= SLB_DES_CHECK;
                            pass_q  <= 1'b1;
                        end
                    end else begin
                        frame_err_q <= frame_err_q | word_err;
                    end
                end
                SLB_DES_CHECK: begin
                    if (!enable) begin
                        state_q <= SLB_DES_IDLE;
                        pass_q  <= !(any_err_q || frame_err_q || word_err);
                    end else if (link.fwd_valid && link.fwd_frame) begin
                        frame_err_q <= word_err;
                        pass_q      <= !frame_err_q;
                        if (frame_err_q) begin
                            any_err_q <= 1'b1;
                            if (err_count_q != 8'hff) begin
                                err_count_q <= err_count_q + 8'h01;
                            end
                        end
                    end else begin
                        pass_q      <= 1'b1;
                        frame_err_q <= frame_err_q | word_err;
                    end
                end
                default: begin
                    state_q <= SLB_DES_IDLE;
                end
            endcase
        end
    end

endmodule : slb_des

`default_nettype wire

// file: rtl/slb_ser.sv
// Serializer end: video path, test pattern source, back-channel checker,
// AXI4-Lite register slave and interrupt.
// Assumes the deserializer end drives the back channel on the same clock.
`include "slb_params.svh"
`default_nettype none

module slb_ser #(
    parameter int FRAME_CYC  = `SLB_FRAME_CYC,
    parameter int BC_TIMEOUT = `SLB_BC_TIMEOUT,
    parameter int LOCK_GOOD  = `SLB_BC_LOCK_GOOD
) (
    // Clock and reset
    input  wire logic               aclk,
    input  wire logic               aclken,
    input  wire logic               aresetn,
    // Video input
    input  wire slb_pkg::slb_word_t video_in,
    // AXI4-Lite write
    input  wire logic               awvalid,
    output var  logic               awready,
    input  wire logic [7:0]         awaddr,
    input  wire logic               wvalid,
    output var  logic               wready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    output var  logic               bvalid,
    input  wire logic               bready,
    output var  logic [1:0]         bresp,
    // AXI4-Lite read
    input  wire logic               arvalid,
    output var  logic               arready,
    input  wire logic [7:0]         araddr,
    output var  logic               rvalid,
    input  wire logic               rready,
    output var  logic [31:0]        rdata,
    output var  logic [1:0]         rresp,
    // Interrupt
    output var  logic               irq,
    // Link
    slb_link_if.ser                 link
);
    import slb_pkg::*;

    localparam int FCW = $clog2(FRAME_CYC);

    slb_ser_state_t state_q;
    slb_word_t      lfsr_q;
    slb_word_t      fwd_word_q;
    logic           fwd_dcb_q;
    logic           fwd_frame_q;
    logic           fwd_valid_q;
    logic [FCW-1:0] frame_cnt_q;
    logic [15:0]    bc_idle_q;
    logic [3:0]     bc_good_q;
    logic           bc_lock_q;
    logic           req_q;
    logic           csel_q;
    logic           arm_q;
    logic [7:0]     crc_cnt_q;
    logic [3:0]     irq_stat_q;
    logic [3:0]     irq_en_q;
    logic [7:0]     awaddr_q;
    logic [31:0]    wdata_q;
    logic           wstrb0_q;
    logic           aw_held_q;
    logic           w_held_q;

    logic           frame_end;
    logic           in_test;
    logic           wr_fire;
    logic           ctrl_wr;
    logic           arm_fall;
    logic           crc_clr;
    logic           bc_bad;
    logic           crc_event;
    logic           entering;
    logic           leaving;
    logic           link_event;
    slb_word_t      scr;
    slb_word_t      scrambled;
    logic [3:0]     irq_ev;

    // Tells whether an offset is one of the block's registers.
    function automatic logic reg_mapped(input logic [7:0] a);
        return (a == `SLB_REG_CTRL) || (a == `SLB_REG_STATUS) || (a == `SLB_REG_CRCCNT) ||
               (a == `SLB_REG_IRQ_STAT) || (a == `SLB_REG_IRQ_CLR) || (a == `SLB_REG_IRQ_EN);
    endfunction : reg_mapped

    assign frame_end = (frame_cnt_q == FCW'(FRAME_CYC - 1));
    assign in_test   = (state_q == SLB_SER_TEST) || (state_q == SLB_SER_LEAVING);
    assign wr_fire   = aw_held_q && w_held_q && !bvalid;
    assign ctrl_wr   = wr_fire && wstrb0_q && (awaddr_q == `SLB_REG_CTRL);
    assign arm_fall  = ctrl_wr && arm_q && !wdata_q[`SLB_CTRL_ARM_BIT];
    assign crc_clr   = ctrl_wr && wdata_q[`SLB_CTRL_CRCCLR_BIT];
    assign bc_bad    = link.bc_valid && (slb_crc8(link.bc_data) != link.bc_crc);
    assign crc_event = bc_lock_q && bc_bad;
    assign entering  = (state_q == SLB_SER_ARMED) && req_q && arm_fall;
    assign leaving   = (state_q == SLB_SER_LEAVING) && !req_q && frame_end;
    assign link_event = link.bc_valid ? (!bc_bad && !bc_lock_q && bc_good_q == 4'(LOCK_GOOD - 1))
                                      : (bc_lock_q && bc_idle_q == 16'(BC_TIMEOUT - 1));
    assign scr       = (frame_cnt_q == '0) ? `SLB_LFSR_SEED : lfsr_q;
    assign scrambled = (in_test ? '0 : video_in) ^ scr;

    assign link.fwd_word  = fwd_word_q;
    assign link.fwd_dcb   = fwd_dcb_q;
    assign link.fwd_frame = fwd_frame_q;
    assign link.fwd_valid = fwd_valid_q;

    // ****************************************
    // Forward data path
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_cnt_q <= '0;
            lfsr_q      <= `SLB_LFSR_SEED;
            fwd_word_q  <= '0;
            fwd_dcb_q   <= 1'b0;
            fwd_frame_q <= 1'b0;
            fwd_valid_q <= 1'b0;
        end else if (aclken) begin
            frame_cnt_q <= frame_end ? '0 : frame_cnt_q + FCW'(1);
            lfsr_q      <= slb_lfsr_next(scr);
            fwd_dcb_q   <= slb_heavy(scrambled);
            fwd_word_q  <= slb_heavy(scrambled) ? ~scrambled : scrambled;
            fwd_frame_q <= (frame_cnt_q == '0);
            fwd_valid_q <= 1'b1;
        end
    end

    // ****************************************
    // Back-channel link detect and request
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bc_idle_q <= 16'h0000;
            bc_good_q <= 4'h0;
            bc_lock_q <= 1'b0;
            req_q     <= 1'b0;
            csel_q    <= 1'b0;
        end else if (aclken) begin
            if (link.bc_valid) begin
                bc_idle_q <= 16'h0000;
                if (bc_bad) begin
                    bc_good_q <= 4'h0;
                end else begin
                    if (bc_good_q != 4'(LOCK_GOOD - 1)) begin
                        bc_good_q <= bc_good_q + 4'h1;
                    end else begin
                        bc_lock_q <= 1'b1;
                    end
                    if (bc_lock_q) begin
                        req_q  <= link.bc_data[0];
                        csel_q <= link.bc_data[1];
                    end
                end
            end else if (bc_idle_q == 16'(BC_TIMEOUT - 1)) begin
                bc_idle_q <= 16'h0000;
                bc_good_q <= 4'h0;
                bc_lock_q <= 1'b0;
                req_q     <= 1'b0;
            end else begin
                bc_idle_q <= bc_idle_q + 16'h0001;
            end
        end
    end

    // ****************************************
    // Test mode sequence
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= SLB_SER_NORMAL;
        end else if (aclken) begin
            case (state_q)
                SLB_SER_NORMAL: begin
                    if (req_q && bc_lock_q) begin
                        state_q <= SLB_SER_ARMED;
                    end
                end
                SLB_SER_ARMED: begin
                    if (!req_q) begin
                        state_q <= SLB_SER_NORMAL;
                    end else if (arm_fall) begin
                        state_q <= SLB_SER_TEST;
                    end
                end
                SLB_SER_TEST: begin
                    if (!req_q) begin
                        state_q <= SLB_SER_LEAVING;
                    end
                end
                SLB_SER_LEAVING: begin
                    if (req_q) begin
                        state_q <= SLB_SER_TEST;
                    end else if (frame_end) begin
                        state_q <= SLB_SER_NORMAL;
                    end
                end
                default: begin
                    state_q <= SLB_SER_NORMAL;
                end
            endcase
        end
    end

    // ****************************************
    // CRC error count
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            crc_cnt_q <= 8'h00;
        end else if (aclken) begin
            if (entering) begin
                crc_cnt_q <= 8'h00;
            end else if (in_test && crc_event) begin
                crc_cnt_q <= crc_clr ? 8'h01 : ((crc_cnt_q == 8'hff) ? 8'hff : crc_cnt_q + 8'h01);
            end else if (crc_clr) begin
                crc_cnt_q <= 8'h00;
            end
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    assign irq_ev = {link_event, in_test && crc_event, leaving, entering};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= 4'h0;
            irq_en_q   <= 4'h0;
            irq        <= 1'b0;
        end else if (aclken) begin
            if (wr_fire && wstrb0_q && awaddr_q == `SLB_REG_IRQ_CLR) begin
                irq_stat_q <= (irq_stat_q & ~wdata_q[3:0]) | irq_ev;
            end else begin
                irq_stat_q <= irq_stat_q | irq_ev;
            end
            if (wr_fire && wstrb0_q && awaddr_q == `SLB_REG_IRQ_EN) begin
                irq_en_q <= wdata_q[3:0];
            end
            irq <= |(irq_stat_q & irq_en_q);
        end
    end

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready   <= 1'b0;
            aw_held_q <= 1'b0;
            awaddr_q  <= 8'h00;
            wready    <= 1'b0;
            w_held_q  <= 1'b0;
            wdata_q   <= 32'h0000_0000;
            wstrb0_q  <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= `SLB_RESP_OKAY;
            arm_q     <= 1'b0;
        end else if (aclken) begin
            if (awvalid && awready) begin
                awaddr_q  <= awaddr;
                aw_held_q <= 1'b1;
                awready   <= 1'b0;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
                awready   <= 1'b1;
            end else begin
                awready   <= !aw_held_q;
            end
            if (wvalid && wready) begin
                wdata_q  <= wdata;
                wstrb0_q <= wstrb[0];
                w_held_q <= 1'b1;
                wready   <= 1'b0;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
                wready   <= 1'b1;
            end else begin
                wready   <= !w_held_q;
            end
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp  <= reg_mapped(awaddr_q) ? `SLB_RESP_OKAY : `SLB_RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
            if (ctrl_wr) begin
                arm_q <= wdata_q[`SLB_CTRL_ARM_BIT];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `SLB_RESP_OKAY;
        end else if (aclken) begin
            arready <= !rvalid && !(arvalid && arready);
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp  <= reg_mapped(araddr) ? `SLB_RESP_OKAY : `SLB_RESP_SLVERR;
                case (araddr)
                    `SLB_REG_CTRL:     rdata <= {26'h0, arm_q, 5'h00};
                    `SLB_REG_STATUS:   rdata <= {28'h0, csel_q, req_q, in_test, bc_lock_q};
                    `SLB_REG_CRCCNT:   rdata <= {24'h0, crc_cnt_q};
                    `SLB_REG_IRQ_STAT: rdata <= {28'h0, irq_stat_q};
                    `SLB_REG_IRQ_EN:   rdata <= {28'h0, irq_en_q};
                    default:           rdata <= 32'h0000_0000;
                endcase
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

endmodule : slb_ser

`default_nettype wire

// file: test/slb_link_properties.sv
// Checker of the link between the two ends: framing, back-channel coding, balance.
// Assumes one clock and a synchronous active-low reset shared by both ends.
`default_nettype none
module slb_link_properties #(
    parameter int FRAME_CYC = 16,
    parameter int BC_PERIOD = 16
) (
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               fwd_valid,
    input wire logic               fwd_frame,
    input wire slb_pkg::slb_word_t fwd_word,
    input wire logic               fwd_dcb,
    input wire logic               bc_valid,
    input wire logic [7:0]         bc_data,
    input wire logic [7:0]         bc_crc
);
    function automatic logic [7:0] crc_of(input logic [7:0] d);
        logic [7:0] c;
        c = d;
        for (int i = 0; i < 8; i++) begin
            c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
        end
        return c;
    endfunction : crc_of
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_FWD_VALID: assert property ($past(aresetn) |-> fwd_valid)
        else $error("forward valid dropped");
    AST_FRAME_PERIOD: assert property (fwd_frame |-> ##FRAME_CYC fwd_frame)
        else $error("frame start spacing wrong");
    AST_FRAME_GAP: assert property (fwd_frame |=> !fwd_frame [*8])
        else $error("frame start too soon");
    AST_BC_PERIOD: assert property (bc_valid |-> ##BC_PERIOD bc_valid)
        else $error("back-channel frame spacing wrong");
    AST_BC_GAP: assert property (bc_valid |=> !bc_valid [*8])
        else $error("back-channel frame too soon");
    AST_BC_CRC: assert property (bc_valid |-> bc_crc == crc_of(bc_data))
        else $error("back-channel check byte wrong");
    AST_CRC_FOLLOWS: assert property ($changed(bc_crc) |-> $changed(bc_data))
        else $error("check byte changed alone");
    AST_BALANCE: assert property (fwd_valid |-> $countones(fwd_word) <= 17)
        else $error("forward word not balanced");
    cover property (fwd_frame);
    cover property (bc_valid && bc_data[0]);
    cover property (fwd_valid && fwd_dcb);
endmodule : slb_link_properties
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench: both ends joined, registers reached over AXI4-Lite.
// Assumes shortened frame, back-channel and timeout counts set at the instances.
`include "slb_params.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import slb_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, selftest_enable_pin = 1'b0, selftest_clock_select;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic selftest_enable_cfg = 1'b0;
    logic [3:0] wstrb = 4'hf;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, err_count_q;
    logic [31:0] wdata = 32'h0, rdata, rd_q;
    logic [1:0] bresp, rresp, rs;
    logic awready, wready, bvalid, arready, rvalid, irq, pass_q, lock_q, rx_frame_q;
    slb_word_t video_in = 35'h0, rx_data_q;
    int num_errors = 0, n_tests = 0, seed = 96, bad;
    always #5 aclk = ~aclk;
    always @(posedge aclk) video_in <= 35'({$random(seed), $random(seed)});
    slb_link_if i_slb_link_if ();
    slb_ser #(.FRAME_CYC(16), .BC_TIMEOUT(64)) i_slb_ser (.aclk, .aclken(1'b1), .aresetn,
        .video_in, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
        .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
        .rresp, .irq, .link(i_slb_link_if));
    slb_des #(.BC_PERIOD(16)) i_slb_des (.aclk, .aclken(1'b1), .aresetn, .selftest_enable_pin,
        .selftest_enable_cfg, .selftest_clock_select, .pass_q, .lock_q, .err_count_q,
        .rx_data_q, .rx_frame_q, .link(i_slb_link_if));
    slb_link_properties i_slb_link_properties (.aclk,
        .aresetn, .fwd_valid(i_slb_link_if.fwd_valid), .fwd_frame(i_slb_link_if.fwd_frame),
        .fwd_word(i_slb_link_if.fwd_word), .fwd_dcb(i_slb_link_if.fwd_dcb),
        .bc_valid(i_slb_link_if.bc_valid), .bc_data(i_slb_link_if.bc_data),
        .bc_crc(i_slb_link_if.bc_crc));
    task automatic give_verdict();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
            num_errors++;
        end
    endtask : chk
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 2000) begin
            num_errors++;
            give_verdict();
        end
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        tick(n);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            tick(n);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int n = 0;
        tick(n);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            tick(n);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd_q = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : rd
    task automatic poll(input int b, input logic v);
        rd(`SLB_REG_STATUS);
        for (int k = 0; k < 80 && rd_q[b] !== v; k++) rd(`SLB_REG_STATUS);
    endtask : poll
    function automatic logic [31:0] exp_status(input logic cs);
        return {28'h0, cs, 3'b111};
    endfunction : exp_status
    initial begin
        selftest_clock_select = 1'($random(seed));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        poll(`SLB_STAT_LINK_BIT, 1'b1);
        chk("link detect", rd_q[0], 1'b1);
        rd(8'h08);
        chk("unmapped read", rs, `SLB_RESP_SLVERR);
        wr(`SLB_REG_IRQ_EN, 32'h1);
        $display("test link done");
        bad = $random(seed) & 1;
        selftest_enable_cfg <= (bad != 0);
        selftest_enable_pin <= (bad == 0);
        poll(`SLB_STAT_REQ_BIT, 1'b1);
        wstrb <= 4'h0;
        wr(`SLB_REG_CTRL, 32'h20);
        wstrb <= 4'hf;
        rd(`SLB_REG_CTRL);
        chk("arm masked", rd_q, 32'h0);
        wr(`SLB_REG_CTRL, 32'h20);
        wr(`SLB_REG_CTRL, 32'h00);
        rd(`SLB_REG_STATUS);
        chk("status in test", rd_q, exp_status(selftest_clock_select));
        rd(`SLB_REG_CRCCNT);
        chk("crc count at entry", rd_q, 32'h0);
        chk("irq raised", irq, 1'b1);
        wr(`SLB_REG_IRQ_CLR, 32'h1);
        @(posedge aclk);
        chk("irq cleared", irq, 1'b0);
        bad = 0;
        while (rx_frame_q !== 1'b1 && bad < 100) tick(bad);
        chk("frame seen", bad < 100, 1'b1);
        bad = 0;
        for (int i = 0; i < 64; i++) begin
            @(posedge aclk);
            if (rx_data_q !== 35'h0 || pass_q !== 1'b1 || lock_q !== 1'b1) bad++;
        end
        chk("clean run", bad, 0);
        chk("errored frames", err_count_q, 8'h00);
        $display("test run done");
        selftest_enable_pin <= 1'b0;
        selftest_enable_cfg <= 1'b0;
        poll(`SLB_STAT_TEST_BIT, 1'b0);
        chk("held result", pass_q, 1'b1);
        rd(`SLB_REG_CRCCNT);
        chk("crc count kept", rd_q, 32'h0);
        rd(`SLB_REG_IRQ_STAT);
        chk("leave event", rd_q[1], 1'b1);
        chk("irq status", rd_q[3:2], 2'b10);
        chk("irq masked", irq, 1'b0);
        bad = 0;
        while (rx_data_q === 35'h0 && bad < 100) tick(bad);
        chk("video resumed", bad < 100, 1'b1);
        chk("result kept", pass_q, 1'b1);
        $display("test leave done");
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
